// *** include/bcr_map.svh ***
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH
// ==========================================
// register offsets (byte addresses)
`define BCR_OFF_CTRL   12'h000
`define BCR_OFF_CNT_C  12'h004
`define BCR_OFF_CNT_D  12'h008
`define BCR_OFF_STAT   12'h00c
// ==========================================
// reset values and field masks
`define BCR_RST_CTRL   32'h00000000
`define BCR_RST_CNT    12'h000
`define BCR_FLAG_MASK  32'hc0c0c0c0
`define BCR_CTRL_MASK  32'h0c1c2c2c
`define BCR_CNT_W      12
`define BCR_CNT_ONE    12'h001
// ==========================================
// field positions in break_control
`define BCR_B_PROC_A   31
`define BCR_B_DMA_A    30
`define BCR_B_TRACE    27
`define BCR_B_FBA_A    26
`define BCR_B_PROC_B   23
`define BCR_B_DMA_B    22
`define BCR_B_SEQ_HI   20
`define BCR_B_SEQ_LO   19
`define BCR_B_FBA_B    18
`define BCR_B_PROC_C   15
`define BCR_B_DMA_C    14
`define BCR_B_CNT_EN_C 13
`define BCR_B_DATA_C   11
`define BCR_B_FBA_C    10
`define BCR_B_PROC_D   7
`define BCR_B_DMA_D    6
`define BCR_B_CNT_EN_D 5
`define BCR_B_DATA_D   3
`define BCR_B_FBA_D    2
// status register layout
`define BCR_S_STAGE_LO 30
`define BCR_S_CNT_D_LO 16
`endif

// *** include/bcr_pkg.sv ***
package bcr_pkg;
  // ==========================================
  // sequence selection field
  typedef enum logic [1:0] {
    BCR_SEQ_INDEP = 2'b00,
    BCR_SEQ_CD    = 2'b01,
    BCR_SEQ_BCD   = 2'b10,
    BCR_SEQ_ABCD  = 2'b11
  } bcr_seq_e;
  // chain stage: channel awaited next, gray along a-b-c-d
  typedef enum logic [1:0] {
    BCR_ST_A = 2'b00,
    BCR_ST_B = 2'b01,
    BCR_ST_C = 2'b11,
    BCR_ST_D = 2'b10
  } bcr_stage_e;
endpackage

// *** core/bcr_exec_count.sv ***
`timescale 1ns/1ns
`include "bcr_map.svh"
// ==========================================
// execution-count gate for one channel
module bcr_exec_count (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   load,
  input  wire logic [`BCR_CNT_W-1:0]  load_val,
  input  wire logic                   en,
  input  wire logic                   hit,
  output logic                        fire,
  output logic [`BCR_CNT_W-1:0]       count
);
  logic [`BCR_CNT_W-1:0] count_r;
  logic                  last;

  // at one or below, the next occurrence requests the break
  assign last  = (count_r <= `BCR_CNT_ONE);
  assign fire  = hit & (~en | last);
  assign count = count_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= `BCR_RST_CNT;
    end else if (load) begin
      count_r <= load_val;
    end else if (en && hit && !last) begin
      count_r <= count_r - `BCR_CNT_ONE;
    end
  end
endmodule // bcr_exec_count

// *** core/bcr_chain.sv ***
`timescale 1ns/1ns
// ==========================================
// sequential condition chaining across channels
module bcr_chain (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clr,
  input  wire bcr_pkg::bcr_seq_e mode,
  input  wire logic [3:0]        hit,
  output logic [3:0]             fire,
  output bcr_pkg::bcr_stage_e    stage
);
  bcr_pkg::bcr_stage_e stage_r;
  bcr_pkg::bcr_stage_e stage_nxt;
  bcr_pkg::bcr_stage_e start;
  bcr_pkg::bcr_seq_e   mode_r;

  assign stage = stage_r;

  always_comb begin
    case (mode)
      bcr_pkg::BCR_SEQ_ABCD: start = bcr_pkg::BCR_ST_A;
      bcr_pkg::BCR_SEQ_BCD:  start = bcr_pkg::BCR_ST_B;
      default:               start = bcr_pkg::BCR_ST_C;
    endcase
  end

  always_comb begin
    fire      = 4'h0;
    stage_nxt = stage_r;
    if (mode == bcr_pkg::BCR_SEQ_INDEP) begin
      fire = hit;
    end else begin
      if (mode == bcr_pkg::BCR_SEQ_CD) begin
        fire[1:0] = hit[1:0];
      end else if (mode == bcr_pkg::BCR_SEQ_BCD) begin
        fire[0] = hit[0];
      end
      case (stage_r)
        bcr_pkg::BCR_ST_A: if (hit[0]) stage_nxt = bcr_pkg::BCR_ST_B;
        bcr_pkg::BCR_ST_B: if (hit[1]) stage_nxt = bcr_pkg::BCR_ST_C;
        bcr_pkg::BCR_ST_C: if (hit[2]) stage_nxt = bcr_pkg::BCR_ST_D;
        default: begin
          if (hit[3]) begin
            fire[3]   = 1'b1;
            stage_nxt = start;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= bcr_pkg::BCR_ST_C;
      mode_r  <= bcr_pkg::BCR_SEQ_INDEP;
    end else begin
      mode_r <= mode;
      // a new mode or a manual reset restarts the chain
      if (clr || mode != mode_r) begin
        stage_r <= start;
      end else begin
        stage_r <= stage_nxt;
      end
    end
  end
endmodule // bcr_chain

// *** core/bcr_top.sv ***
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "bcr_map.svh"
module bcr_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        manual_rst,
  input  wire logic [3:0]  cond_proc,
  input  wire logic [3:0]  cond_dma,
  input  wire logic [3:0]  cond_fetch,
  input  wire logic [1:0]  data_hit_cd,
  output logic             break_req,
  output logic             break_after,
  output logic             trace_enable
);
  // ==========================================
  // registers and nets
  logic [31:0]           ctrl_r;
  logic [31:0]           ctrl_nxt;
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  break_req_r;
  logic                  break_after_r;
  logic                  trace_enable_r;
  logic                  setup;
  logic                  wr_go;
  logic                  wr_ctrl;
  logic                  wr_cnt_c;
  logic                  wr_cnt_d;
  logic [3:0]            qual;
  logic [3:0]            occur;
  logic [3:0]            gated;
  logic [3:0]            fire;
  logic [3:0]            proc_set;
  logic [3:0]            dma_set;
  logic [3:0]            after_sel;
  logic [1:0]            cnt_fire;
  logic [`BCR_CNT_W-1:0] cnt_c;
  logic [`BCR_CNT_W-1:0] cnt_d;
  bcr_pkg::bcr_seq_e     seq_mode;
  bcr_pkg::bcr_stage_e   stage;

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign break_req    = break_req_r;
  assign break_after  = break_after_r;
  assign trace_enable = trace_enable_r;

  // ==========================================
  // helpers
  // software write keeps a set flag only when a 1 is written; a new match wins
  function automatic logic upd_flag(input logic old, input logic wr,
                                    input logic wbit, input logic set);
    upd_flag = (wr ? (old & wbit) : old) | set;
  endfunction

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  // ==========================================
  // apb slave
  assign setup    = psel & ~penable;
  assign wr_go    = psel & penable & pready_r & pwrite;
  assign wr_ctrl  = wr_go & is_addr(paddr, `BCR_OFF_CTRL);
  assign wr_cnt_c = wr_go & is_addr(paddr, `BCR_OFF_CNT_C);
  assign wr_cnt_d = wr_go & is_addr(paddr, `BCR_OFF_CNT_D);

  // one wait-free access phase: ready is raised by the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
      if (is_addr(paddr, `BCR_OFF_CTRL)) begin
        prdata_r <= ctrl_r;
      end else if (is_addr(paddr, `BCR_OFF_CNT_C)) begin
        prdata_r[`BCR_CNT_W-1:0] <= cnt_c;
      end else if (is_addr(paddr, `BCR_OFF_CNT_D)) begin
        prdata_r[`BCR_CNT_W-1:0] <= cnt_d;
      end else if (is_addr(paddr, `BCR_OFF_STAT)) begin
        prdata_r[`BCR_S_STAGE_LO+:2]         <= stage;
        prdata_r[`BCR_S_CNT_D_LO+:`BCR_CNT_W] <= cnt_d;
        prdata_r[`BCR_CNT_W-1:0]              <= cnt_c;
      end else begin
        pslverr_r <= 1'b1;
      end
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // ==========================================
  // condition qualification
  assign seq_mode = bcr_pkg::bcr_seq_e'(ctrl_r[`BCR_B_SEQ_HI:`BCR_B_SEQ_LO]);

  always_comb begin
    qual[1:0] = 2'b11;
    // data bus joins the comparison for c and d when enabled
    qual[2] = ~ctrl_r[`BCR_B_DATA_C] | data_hit_cd[0];
    qual[3] = ~ctrl_r[`BCR_B_DATA_D] | data_hit_cd[1];
  end

  assign occur = (cond_proc | cond_dma) & qual;

  // ==========================================
  // execution-count gates for c and d
  bcr_exec_count u_cnt_c (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (wr_cnt_c),
    .load_val (pwdata[`BCR_CNT_W-1:0]),
    .en       (ctrl_r[`BCR_B_CNT_EN_C]),
    .hit      (occur[2]),
    .fire     (cnt_fire[0]),
    .count    (cnt_c)
  );

  bcr_exec_count u_cnt_d (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (wr_cnt_d),
    .load_val (pwdata[`BCR_CNT_W-1:0]),
    .en       (ctrl_r[`BCR_B_CNT_EN_D]),
    .hit      (occur[3]),
    .fire     (cnt_fire[1]),
    .count    (cnt_d)
  );

  assign gated = {cnt_fire[1], cnt_fire[0], occur[1:0]};
  assign proc_set = cond_proc & qual & gated;
  assign dma_set  = cond_dma & qual & gated;

  // ==========================================
  // sequential chaining
  bcr_chain u_chain (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (manual_rst),
    .mode    (seq_mode),
    .hit     (gated),
    .fire    (fire),
    .stage   (stage)
  );

  // ==========================================
  // break control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      // reserved bits never store
      ctrl_nxt = (pwdata & `BCR_CTRL_MASK) | (ctrl_r & `BCR_FLAG_MASK);
    end
    ctrl_nxt[`BCR_B_PROC_A] = upd_flag(ctrl_r[`BCR_B_PROC_A], wr_ctrl,
                                       pwdata[`BCR_B_PROC_A], proc_set[0]);
    ctrl_nxt[`BCR_B_DMA_A]  = upd_flag(ctrl_r[`BCR_B_DMA_A], wr_ctrl,
                                       pwdata[`BCR_B_DMA_A], dma_set[0]);
    ctrl_nxt[`BCR_B_PROC_B] = upd_flag(ctrl_r[`BCR_B_PROC_B], wr_ctrl,
                                       pwdata[`BCR_B_PROC_B], proc_set[1]);
    ctrl_nxt[`BCR_B_DMA_B]  = upd_flag(ctrl_r[`BCR_B_DMA_B], wr_ctrl,
                                       pwdata[`BCR_B_DMA_B], dma_set[1]);
    ctrl_nxt[`BCR_B_PROC_C] = upd_flag(ctrl_r[`BCR_B_PROC_C], wr_ctrl,
                                       pwdata[`BCR_B_PROC_C], proc_set[2]);
    ctrl_nxt[`BCR_B_DMA_C]  = upd_flag(ctrl_r[`BCR_B_DMA_C], wr_ctrl,
                                       pwdata[`BCR_B_DMA_C], dma_set[2]);
    ctrl_nxt[`BCR_B_PROC_D] = upd_flag(ctrl_r[`BCR_B_PROC_D], wr_ctrl,
                                       pwdata[`BCR_B_PROC_D], proc_set[3]);
    ctrl_nxt[`BCR_B_DMA_D]  = upd_flag(ctrl_r[`BCR_B_DMA_D], wr_ctrl,
                                       pwdata[`BCR_B_DMA_D], dma_set[3]);
  end

  // manual reset does not touch this register: contents are left as they were
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `BCR_RST_CTRL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================
  // break request and trace outputs
  always_comb begin
    after_sel[0] = cond_fetch[0] & ctrl_r[`BCR_B_FBA_A];
    after_sel[1] = cond_fetch[1] & ctrl_r[`BCR_B_FBA_B];
    after_sel[2] = cond_fetch[2] & ctrl_r[`BCR_B_FBA_C];
    after_sel[3] = cond_fetch[3] & ctrl_r[`BCR_B_FBA_D];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_req_r   <= 1'b0;
      break_after_r <= 1'b0;
    end else begin
      break_req_r   <= |fire;
      break_after_r <= |(fire & after_sel);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_enable_r <= 1'b0;
    end else begin
      trace_enable_r <= ctrl_r[`BCR_B_TRACE];
    end
  end

  // ==========================================
  // assertions
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r & ~(`BCR_CTRL_MASK | `BCR_FLAG_MASK)) == 32'h00000000)
    else $error("reserved bits of break control are not zero");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr_ctrl && ((ctrl_r & `BCR_FLAG_MASK) != 32'h00000000))
      |=> ((ctrl_r & `BCR_FLAG_MASK) & $past(ctrl_r)) == ($past(ctrl_r) & `BCR_FLAG_MASK))
    else $error("match flag dropped without a software write");

  a_proc_a_set: assert property (@(posedge pclk) disable iff (!presetn)
    cond_proc[0] |=> ctrl_r[`BCR_B_PROC_A])
    else $error("channel a processor flag not set");

  a_dma_a_set: assert property (@(posedge pclk) disable iff (!presetn)
    cond_dma[0] |=> ctrl_r[`BCR_B_DMA_A])
    else $error("channel a dma flag not set");

  a_proc_b_set: assert property (@(posedge pclk) disable iff (!presetn)
    cond_proc[1] |=> ctrl_r[`BCR_B_PROC_B])
    else $error("channel b processor flag not set");

  a_dma_b_set: assert property (@(posedge pclk) disable iff (!presetn)
    cond_dma[1] |=> ctrl_r[`BCR_B_DMA_B])
    else $error("channel b dma flag not set");

  a_write_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !pwdata[`BCR_B_PROC_A] && !cond_proc[0]) |=> !ctrl_r[`BCR_B_PROC_A])
    else $error("writing zero did not clear the flag");

  a_trace_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 (trace_enable_r == $past(pwdata[`BCR_B_TRACE], 2)))
    else $error("trace enable does not follow the written bit");

  a_fetch_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_mode == bcr_pkg::BCR_SEQ_INDEP && cond_proc[0] && cond_fetch[0]
      && (cond_fetch[3:1] & gated[3:1]) == 3'b000)
      |=> (break_req_r && break_after_r == $past(ctrl_r[`BCR_B_FBA_A])))
    else $error("channel a break timing select ignored");

  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[`BCR_B_CNT_EN_C] && cnt_c > `BCR_CNT_ONE && !wr_ctrl && !wr_cnt_c
      && !ctrl_r[`BCR_B_PROC_C] && !ctrl_r[`BCR_B_DMA_C] && occur[2])
      |=> (!ctrl_r[`BCR_B_PROC_C] && cnt_c == $past(cnt_c) - `BCR_CNT_ONE))
    else $error("count break fired before the count was reached");

  a_proc_c_set: assert property (@(posedge pclk) disable iff (!presetn)
    proc_set[2] |=> ctrl_r[`BCR_B_PROC_C])
    else $error("channel c processor flag not set");

  a_dma_c_set: assert property (@(posedge pclk) disable iff (!presetn)
    dma_set[2] |=> ctrl_r[`BCR_B_DMA_C])
    else $error("channel c dma flag not set");

  a_proc_d_set: assert property (@(posedge pclk) disable iff (!presetn)
    proc_set[3] |=> ctrl_r[`BCR_B_PROC_D])
    else $error("channel d processor flag not set");

  a_dma_d_set: assert property (@(posedge pclk) disable iff (!presetn)
    dma_set[3] |=> ctrl_r[`BCR_B_DMA_D])
    else $error("channel d dma flag not set");

  a_data_gate_c: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[`BCR_B_DATA_C] && !data_hit_cd[0] && cond_proc[2] && !ctrl_r[`BCR_B_PROC_C])
      |=> !ctrl_r[`BCR_B_PROC_C])
    else $error("channel c matched without its data bus condition");

  a_data_gate_d: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[`BCR_B_DATA_D] && !data_hit_cd[1] && cond_proc[3] && !ctrl_r[`BCR_B_PROC_D])
      |=> !ctrl_r[`BCR_B_PROC_D])
    else $error("channel d matched without its data bus condition");

  a_count_hold_d: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[`BCR_B_CNT_EN_D] && cnt_d > `BCR_CNT_ONE && !wr_ctrl && !wr_cnt_d
      && !ctrl_r[`BCR_B_PROC_D] && !ctrl_r[`BCR_B_DMA_D] && occur[3])
      |=> (!ctrl_r[`BCR_B_PROC_D] && cnt_d == $past(cnt_d) - `BCR_CNT_ONE))
    else $error("channel d count break fired before the count was reached");

  a_count_fire_c: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[`BCR_B_CNT_EN_C] && cnt_c == `BCR_CNT_ONE && occur[2] && cond_proc[2])
      |=> ctrl_r[`BCR_B_PROC_C])
    else $error("count break missing once the count was reached");

  a_chain_abcd: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_mode == bcr_pkg::BCR_SEQ_ABCD && stage != bcr_pkg::BCR_ST_D) |=> !break_req_r)
    else $error("break requested before the chain reached channel d");

  a_chain_cd: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_mode == bcr_pkg::BCR_SEQ_CD && stage != bcr_pkg::BCR_ST_D && gated[1:0] == 2'b00)
      |=> !break_req_r)
    else $error("break requested before channel c was met");

  a_chain_end: assert property (@(posedge pclk) disable iff (!presetn)
    (seq_mode != bcr_pkg::BCR_SEQ_INDEP && stage == bcr_pkg::BCR_ST_D && gated[3])
      |=> break_req_r)
    else $error("completed chain did not request a break");

  a_manual_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (manual_rst && !wr_ctrl && proc_set == 4'h0 && dma_set == 4'h0)
      |=> ctrl_r == $past(ctrl_r))
    else $error("manual reset changed break control");

  a_reset_outputs: assert property (@(posedge pclk)
    $rose(presetn) |-> (!break_req_r && !break_after_r && !trace_enable_r && !pready_r))
    else $error("outputs not idle after power-on reset");

  a_reset_clear: assert property (@(posedge pclk)
    $rose(presetn) |-> (ctrl_r == `BCR_RST_CTRL))
    else $error("break control not zero after power-on reset");
endmodule // bcr_top

// *** verif/bcr_bench.sv ***
`timescale 1ns/1ns
`include "bcr_map.svh"
module bcr_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        manual_rst;
  logic [3:0]  cond_proc;
  logic [3:0]  cond_dma;
  logic [3:0]  cond_fetch;
  logic [1:0]  data_hit_cd;
  logic        break_req;
  logic        break_after;
  logic        trace_enable;
  int          mismatches;
  int          cmp_count;
  logic [31:0] acc;
  int          fba [4] = '{26, 18, 10, 2};

  bcr_top u_bcr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .manual_rst(manual_rst), .cond_proc(cond_proc), .cond_dma(cond_dma),
    .cond_fetch(cond_fetch), .data_hit_cd(data_hit_cd), .break_req(break_req),
    .break_after(break_after), .trace_enable(trace_enable));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ==========================================
  // checking and closing
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ==========================================
  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      complete_run();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h00000000, rd, err);
    check(nm, rd, exp);
    check("pslverr", {31'h0, err}, {31'h0, exp_err});
  endtask

  // one-cycle condition on one channel, then look at the break request
  task automatic pulse(input int ch, input logic dma, input logic fetch,
                       input logic [1:0] dh, input logic exp_req, input logic exp_aft);
    logic [3:0] sel;
    sel = 4'h1 << ch;
    @(posedge pclk);
    if (dma) begin
      cond_dma <= sel;
    end else begin
      cond_proc <= sel;
    end
    cond_fetch  <= fetch ? sel : 4'h0;
    data_hit_cd <= dh;
    @(posedge pclk);
    cond_proc   <= 4'h0;
    cond_dma    <= 4'h0;
    cond_fetch  <= 4'h0;
    data_hit_cd <= 2'h0;
    #1;
    check("break_req", {31'h0, break_req}, {31'h0, exp_req});
    if (exp_req) check("break_after", {31'h0, break_after}, {31'h0, exp_aft});
    @(posedge pclk);
    #1;
    check("break_req end", {31'h0, break_req}, 32'h00000000);
  endtask

  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    manual_rst = 1'b0;
    cond_proc = 4'h0;
    cond_dma = 4'h0;
    cond_fetch = 4'h0;
    data_hit_cd = 2'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl reset", `BCR_OFF_CTRL, 32'h00000000, 1'b0);
    check("trace reset", {31'h0, trace_enable}, 32'h00000000);
    $display("test reset done");
    // reserved bits read zero, flags cannot be set by a write of one
    wr(`BCR_OFF_CTRL, 32'hffffffff);
    @(posedge pclk);
    #1;
    check("trace on", {31'h0, trace_enable}, 32'h00000001);
    rd_chk("ctrl all", `BCR_OFF_CTRL, 32'h0c1c2c2c, 1'b0);
    wr(`BCR_OFF_STAT, 32'h00000000);
    rd_chk("ctrl after status write", `BCR_OFF_CTRL, 32'h0c1c2c2c, 1'b0);
    rd_chk("unmapped", 12'h010, 32'h00000000, 1'b1);
    $display("test fields done");
    // independent mode: every flag of every channel
    wr(`BCR_OFF_CTRL, 32'h00000000);
    acc = 32'h00000000;
    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 2; k++) begin
        pulse(ch, k[0], 1'b0, 2'h0, 1'b1, 1'b0);
        acc = acc | (32'h80000000 >> (8 * ch + k));
        rd_chk("flag", `BCR_OFF_CTRL, acc, 1'b0);
      end
    end
    repeat (6) @(posedge pclk);
    rd_chk("flags held", `BCR_OFF_CTRL, 32'hc0c0c0c0, 1'b0);
    wr(`BCR_OFF_CTRL, 32'hc0c0c0c0);
    rd_chk("flags kept", `BCR_OFF_CTRL, 32'hc0c0c0c0, 1'b0);
    wr(`BCR_OFF_CTRL, 32'h00000000);
    rd_chk("flags cleared", `BCR_OFF_CTRL, 32'h00000000, 1'b0);
    $display("test flags done");
    // fetch break before or after execution per channel
    for (int ch = 0; ch < 4; ch++) begin
      wr(`BCR_OFF_CTRL, 32'h1 << fba[ch]);
      pulse(ch, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1);
      pulse(ch, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
      wr(`BCR_OFF_CTRL, 32'h00000000);
      pulse(ch, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0);
    end
    $display("test fetch done");
    // data bus compare on c and d
    for (int ch = 2; ch < 4; ch++) begin
      wr(`BCR_OFF_CTRL, (ch == 2) ? 32'h00000800 : 32'h00000008);
      pulse(ch, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
      pulse(ch, 1'b0, 1'b0, 2'h1 << (ch - 2), 1'b1, 1'b0);
    end
    rd_chk("data d", `BCR_OFF_CTRL, 32'h00000088, 1'b0);
    $display("test data done");
    // execution count: third occurrence requests, later ones too
    for (int ch = 2; ch < 4; ch++) begin
      wr((ch == 2) ? `BCR_OFF_CNT_C : `BCR_OFF_CNT_D, 32'h00000003);
      wr(`BCR_OFF_CTRL, (ch == 2) ? 32'h00002000 : 32'h00000020);
      for (int k = 0; k < 4; k++) begin
        pulse(ch, 1'b0, 1'b0, 2'h0, k >= 2, 1'b0);
      end
    end
    rd_chk("count d", `BCR_OFF_CTRL, 32'h000000a0, 1'b0);
    // stage c of the idle chain, both counters parked at one
    rd_chk("status", `BCR_OFF_STAT, 32'hc0010001, 1'b0);
    $display("test count done");
    // chained modes: only d at the end of the chain requests
    for (int m = 1; m < 4; m++) begin
      wr(`BCR_OFF_CTRL, m << 19);
      pulse(3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
      for (int ch = 3 - m; ch < 3; ch++) begin
        pulse(ch, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
      end
      pulse(3, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
    end
    $display("test chain done");
    // manual reset restarts the chain and keeps the register
    wr(`BCR_OFF_CTRL, 32'h08080000);
    pulse(2, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    @(posedge pclk);
    manual_rst <= 1'b1;
    @(posedge pclk);
    manual_rst <= 1'b0;
    pulse(3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    rd_chk("after manual", `BCR_OFF_CTRL, 32'h08088080, 1'b0);
    check("trace kept", {31'h0, trace_enable}, 32'h00000001);
    $display("test manual reset done");
    // power-on reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    check("trace in reset", {31'h0, trace_enable}, 32'h00000000);
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl second reset", `BCR_OFF_CTRL, 32'h00000000, 1'b0);
    $display("test second reset done");
    complete_run();
  end
endmodule // bcr_bench
